// ---- perf_counter_block.sv ----
// module: four chained performance counters with compare and APB access
`timescale 1ns/1ps
module perf_counter_block
(
   // clock, reset, enable
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // monitored unit events, one per counter per unit class (pins)
   input wire logic [3:0] PROTOCOL_ENGINE_UNIT_EVT,
   input wire logic [3:0] LINK_LAYER_UNIT_EVT,
   input wire logic [3:0] ROUTE_THROUGH_UNIT_EVT,
   // interval timer window (pin)
   input wire logic INTERVAL_TIMER_ACTIVE,
   // status and interrupt
   output logic [7:0] GLOBAL_STATUS,
   output logic IRQ
);
   localparam int N = perf_counter_pkg::NUM_COUNTERS;
   localparam int W = perf_counter_pkg::CNT_W;
   localparam int CFG_W = $bits(perf_counter_pkg::cfg_s);

   // ==========================================================
   // input synchronisers
   // ==========================================================
   logic [3:0] pe_s1_reg, pe_s2_reg, ll_s1_reg, ll_s2_reg;
   logic [3:0] ro_s1_reg, ro_s2_reg;
   logic tmr_s1_reg, tmr_s2_reg;

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         pe_s1_reg <= '0;
         pe_s2_reg <= '0;
         ll_s1_reg <= '0;
         ll_s2_reg <= '0;
         ro_s1_reg <= '0;
         ro_s2_reg <= '0;
         tmr_s1_reg <= 1'b0;
         tmr_s2_reg <= 1'b0;
      end
      else if (CE)
      begin
         pe_s1_reg <= PROTOCOL_ENGINE_UNIT_EVT;
         pe_s2_reg <= pe_s1_reg;
         ll_s1_reg <= LINK_LAYER_UNIT_EVT;
         ll_s2_reg <= ll_s1_reg;
         ro_s1_reg <= ROUTE_THROUGH_UNIT_EVT;
         ro_s2_reg <= ro_s1_reg;
         tmr_s1_reg <= INTERVAL_TIMER_ACTIVE;
         tmr_s2_reg <= tmr_s1_reg;
      end
   end

   // ==========================================================
   // register state
   // ==========================================================
   logic [31:0] global_perf_control_reg;
   logic [7:0] irq_status_reg, irq_mask_reg;
   perf_counter_pkg::cfg_s cfg_reg [N];
   logic [W-1:0] count_data_register [N];
   logic [W-1:0] compare_value_register [N];
   logic [7:0] event_selector [N];
   logic [N-1:0] st_cmp_reg, st_ovf_reg, armed_reg;

   // decode: which counter block and which word within it
   function automatic logic cnt_hit(input logic [11:0] a);
      cnt_hit = (a >= perf_counter_pkg::OFF_CNT_BASE) &&
         (a < perf_counter_pkg::OFF_CNT_BASE +
         12'(N) * perf_counter_pkg::CNT_STRIDE);
   endfunction

   function automatic logic [1:0] cnt_idx(input logic [11:0] a);
      logic [11:0] rel;
      rel = a - perf_counter_pkg::OFF_CNT_BASE;
      cnt_idx = rel[5:4];
   endfunction

   logic acc, wr;
   logic [1:0] widx;
   logic [3:0] sub;
   assign acc = PSEL && PENABLE && CE;
   assign wr = acc && PWRITE;
   assign widx = cnt_idx(PADDR);
   assign sub = PADDR[3:0];

   // ==========================================================
   // enable, event and count logic per counter
   // ==========================================================
   logic global_en;
   // local enable and timer are exclusive; one shared signal
   assign global_en =
      global_perf_control_reg[perf_counter_pkg::GC_TIMER_SEL_BIT] ?
      tmr_s2_reg :
      global_perf_control_reg[perf_counter_pkg::GC_LOCAL_EN_BIT];

   logic [N-1:0] unit_evt, status_out, to_partner, en, inc, wrap;
   logic [N-1:0] cmp_hit, cnt_rst, upd;

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_cnt
         localparam int P = g ^ 1; // partner pairing 0-1, 2-3
         // unit class feeding this counter
         always_comb
         begin
            case (cfg_reg[g].unit)
               perf_counter_pkg::UNIT_PROTOCOL: unit_evt[g] = pe_s2_reg[g];
               perf_counter_pkg::UNIT_LINK: unit_evt[g] = ll_s2_reg[g];
               perf_counter_pkg::UNIT_ROUTE: unit_evt[g] = ro_s2_reg[g];
               default: unit_evt[g] = 1'b0;
            endcase
         end
         assign status_out[g] = st_cmp_reg[g] | st_ovf_reg[g];
         // status routed to partner or to global control
         assign to_partner[g] =
            (cfg_reg[g].out == perf_counter_pkg::OUT_PARTNER) &&
            status_out[g];
         // enable source selection
         always_comb
         begin
            case (cfg_reg[g].en)
               perf_counter_pkg::EN_GLOBAL: en[g] = global_en;
               perf_counter_pkg::EN_PARTNER: en[g] = to_partner[P];
               default: en[g] = 1'b0;
            endcase
         end
         // increment source and mode
         logic src_evt;
         always_comb
         begin
            case (cfg_reg[g].src)
               perf_counter_pkg::SRC_EVENT: src_evt = unit_evt[g];
               perf_counter_pkg::SRC_PARTNER: src_evt = to_partner[P];
               perf_counter_pkg::SRC_CLOCK: src_evt = 1'b1;
               default: src_evt = 1'b0;
            endcase
         end
         assign inc[g] = en[g] &&
            ((cfg_reg[g].mode == perf_counter_pkg::MODE_AFTER_EVENT) ?
            (armed_reg[g] || src_evt) : src_evt);
         assign wrap[g] = inc[g] && (&count_data_register[g]);
         // compare modes
         assign cmp_hit[g] =
            (cfg_reg[g].cmp == perf_counter_pkg::CMP_MAX) &&
            (count_data_register[g] == compare_value_register[g]);
         assign upd[g] =
            (cfg_reg[g].cmp == perf_counter_pkg::CMP_UPDATE) &&
            (count_data_register[g] > compare_value_register[g]);
         // reset sources from partner
         always_comb
         begin
            case (cfg_reg[g].rst)
               perf_counter_pkg::RST_P_CMP: cnt_rst[g] = st_cmp_reg[P];
               perf_counter_pkg::RST_P_OVF: cnt_rst[g] = st_ovf_reg[P];
               perf_counter_pkg::RST_P_EVENT: cnt_rst[g] = unit_evt[P];
               default: cnt_rst[g] = 1'b0;
            endcase
         end
      end
   endgenerate

   // clear action from the control register write
   logic [N-1:0] clr_cmd;
   always_comb
   begin
      for (int i = 0; i < N; i++)
         clr_cmd[i] = wr && cnt_hit(PADDR) && (widx == 2'(i)) &&
            (sub == perf_counter_pkg::OFF_SUB_CTRL) &&
            PWDATA[perf_counter_pkg::F_CLR_BIT];
   end

   // ==========================================================
   // counters, compare values and status
   // ==========================================================
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         for (int i = 0; i < N; i++)
         begin
            count_data_register[i] <= '0;
            compare_value_register[i] <= '0;
         end
         st_cmp_reg <= '0;
         st_ovf_reg <= '0;
         armed_reg <= '0;
      end
      else if (CE)
      begin
         for (int i = 0; i < N; i++)
         begin
            if (clr_cmd[i] || cnt_rst[i])
            begin
               count_data_register[i] <= '0;
               st_cmp_reg[i] <= 1'b0;
               st_ovf_reg[i] <= 1'b0;
               armed_reg[i] <= 1'b0;
            end
            else
            begin
               if (wr && cnt_hit(PADDR) && widx == 2'(i) &&
                  sub == perf_counter_pkg::OFF_SUB_DATA)
                  count_data_register[i] <= PWDATA;
               else if (inc[i])
                  count_data_register[i] <= count_data_register[i] + 1'b1;
               if (inc[i])
                  armed_reg[i] <= 1'b1;
               if (cmp_hit[i])
                  st_cmp_reg[i] <= 1'b1;
               if (wrap[i])
                  st_ovf_reg[i] <= 1'b1;
            end
            if (upd[i])
               compare_value_register[i] <= count_data_register[i];
            else if (wr && cnt_hit(PADDR) && widx == 2'(i) &&
               sub == perf_counter_pkg::OFF_SUB_CMP)
               compare_value_register[i] <= PWDATA;
         end
      end
   end

   // ==========================================================
   // configuration registers
   // ==========================================================
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         global_perf_control_reg <= '0;
         irq_mask_reg <= '0;
         for (int i = 0; i < N; i++)
         begin
            cfg_reg[i] <= perf_counter_pkg::cfg_s'(
               perf_counter_pkg::CTRL_RESET[CFG_W-1:0]);
            event_selector[i] <= '0;
         end
      end
      else if (CE && wr)
      begin
         if (PADDR == perf_counter_pkg::OFF_GLOBAL_CTRL)
            global_perf_control_reg <= PWDATA;
         if (PADDR == perf_counter_pkg::OFF_IRQ_MASK)
            irq_mask_reg <= PWDATA[7:0];
         for (int i = 0; i < N; i++)
         begin
            if (cnt_hit(PADDR) && widx == 2'(i))
            begin
               if (sub == perf_counter_pkg::OFF_SUB_CTRL)
               begin
                  cfg_reg[i].unit <= perf_counter_pkg::unit_e'(
                     PWDATA[perf_counter_pkg::F_UNIT_LSB +: 2]);
                  cfg_reg[i].cmp <= perf_counter_pkg::cmp_e'(
                     PWDATA[perf_counter_pkg::F_CMP_LSB +: 2]);
                  cfg_reg[i].rst <= perf_counter_pkg::rst_e'(
                     PWDATA[perf_counter_pkg::F_RST_LSB +: 3]);
                  cfg_reg[i].src <= perf_counter_pkg::src_e'(
                     PWDATA[perf_counter_pkg::F_SRC_LSB +: 2]);
                  cfg_reg[i].mode <= perf_counter_pkg::mode_e'(
                     PWDATA[perf_counter_pkg::F_MODE_LSB +: 2]);
                  cfg_reg[i].out <= perf_counter_pkg::out_e'(
                     PWDATA[perf_counter_pkg::F_OUT_LSB +: 3]);
                  cfg_reg[i].en <= perf_counter_pkg::en_e'(
                     PWDATA[perf_counter_pkg::F_EN_LSB +: 3]);
               end
               if (sub == perf_counter_pkg::OFF_SUB_EVSEL)
                  event_selector[i] <= PWDATA[7:0];
            end
         end
      end
   end

   // ==========================================================
   // interrupts and global status
   // ==========================================================
   logic [7:0] irq_set, irq_clr;
   always_comb
   begin
      for (int i = 0; i < N; i++)
      begin
         irq_set[perf_counter_pkg::IRQ_CMP_LSB + i] = cmp_hit[i] &&
            !st_cmp_reg[i];
         irq_set[perf_counter_pkg::IRQ_OVF_LSB + i] = wrap[i];
      end
      irq_clr = (wr && PADDR == perf_counter_pkg::OFF_IRQ_STATUS) ?
         PWDATA[7:0] : 8'h00;
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         irq_status_reg <= '0;
         IRQ <= 1'b0;
         GLOBAL_STATUS <= '0;
      end
      else if (CE)
      begin
         // set wins over a write-one clear
         irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
         IRQ <= |(((irq_status_reg & ~irq_clr) | irq_set) & irq_mask_reg);
         for (int i = 0; i < N; i++)
         begin
            // only counters routed to global control report here
            GLOBAL_STATUS[perf_counter_pkg::IRQ_CMP_LSB + i] <=
               (cfg_reg[i].out == perf_counter_pkg::OUT_GLOBAL) &&
               st_cmp_reg[i];
            GLOBAL_STATUS[perf_counter_pkg::IRQ_OVF_LSB + i] <=
               (cfg_reg[i].out == perf_counter_pkg::OUT_GLOBAL) &&
               st_ovf_reg[i];
         end
      end
   end

   // ==========================================================
   // apb read path, one-cycle access
   // ==========================================================
   function automatic logic [31:0] ctrl_word(
      input perf_counter_pkg::cfg_s c, input logic sc, input logic so);
      logic [31:0] v;
      v = '0;
      v[perf_counter_pkg::F_UNIT_LSB +: 2] = c.unit;
      v[perf_counter_pkg::F_CMP_LSB +: 2] = c.cmp;
      v[perf_counter_pkg::F_RST_LSB +: 3] = c.rst;
      v[perf_counter_pkg::F_SRC_LSB +: 2] = c.src;
      v[perf_counter_pkg::F_MODE_LSB +: 2] = c.mode;
      v[perf_counter_pkg::F_ST_CMP_BIT] = sc;
      v[perf_counter_pkg::F_ST_OVF_BIT] = so;
      v[perf_counter_pkg::F_OUT_LSB +: 3] = c.out;
      v[perf_counter_pkg::F_EN_LSB +: 3] = c.en;
      ctrl_word = v;
   endfunction

   logic [31:0] rdata_next;
   logic err_next;
   always_comb
   begin
      rdata_next = '0;
      err_next = 1'b0;
      if (PADDR == perf_counter_pkg::OFF_GLOBAL_CTRL)
         rdata_next = global_perf_control_reg;
      else if (PADDR == perf_counter_pkg::OFF_IRQ_STATUS)
         rdata_next = {24'h00_0000, irq_status_reg};
      else if (PADDR == perf_counter_pkg::OFF_IRQ_MASK)
         rdata_next = {24'h00_0000, irq_mask_reg};
      else if (cnt_hit(PADDR))
      begin
         case (sub)
            perf_counter_pkg::OFF_SUB_CTRL: rdata_next = ctrl_word(
               cfg_reg[widx], st_cmp_reg[widx], st_ovf_reg[widx]);
            perf_counter_pkg::OFF_SUB_DATA:
               rdata_next = count_data_register[widx];
            perf_counter_pkg::OFF_SUB_CMP:
               rdata_next = compare_value_register[widx];
            perf_counter_pkg::OFF_SUB_EVSEL:
               rdata_next = {24'h00_0000, event_selector[widx]};
            default: err_next = 1'b1;
         endcase
      end
      else
         err_next = 1'b1;
   end

   // pready is a registered pulse: access phase ends one cycle after entry
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end
      else if (CE)
      begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && err_next;
         if (PSEL && !PENABLE && !PWRITE)
            PRDATA <= rdata_next;
      end
   end
endmodule

// ---- perf_counter_pkg.sv ----
// package: register map, field layouts and modes of the performance counters
package perf_counter_pkg;
   localparam int NUM_COUNTERS = 4;
   localparam int CNT_W = 32;
   localparam int IDX_W = 2;
   localparam int SEL_W = 3;
   localparam int NUM_UNITS = 3;

   // register map, each counter owns a block of four words
   localparam logic [11:0] OFF_GLOBAL_CTRL = 12'h0_000;
   localparam logic [11:0] OFF_IRQ_STATUS = 12'h0_004;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h0_008;
   localparam logic [11:0] OFF_CNT_BASE = 12'h0_100;
   localparam logic [11:0] CNT_STRIDE = 12'h0_010;
   localparam logic [3:0] OFF_SUB_CTRL = 4'h0;
   localparam logic [3:0] OFF_SUB_DATA = 4'h4;
   localparam logic [3:0] OFF_SUB_CMP = 4'h8;
   localparam logic [3:0] OFF_SUB_EVSEL = 4'hC;

   // global control bits
   localparam int GC_LOCAL_EN_BIT = 0;
   localparam int GC_TIMER_SEL_BIT = 1;

   // counter_control_status field positions
   localparam int F_UNIT_LSB = 29;
   localparam int F_CMP_LSB = 18;
   localparam int F_RST_LSB = 15;
   localparam int F_SRC_LSB = 12;
   localparam int F_MODE_LSB = 10;
   localparam int F_ST_CMP_BIT = 9;
   localparam int F_ST_OVF_BIT = 8;
   localparam int F_OUT_LSB = 5;
   localparam int F_EN_LSB = 2;
   localparam int F_CLR_BIT = 0;
   localparam logic [31:0] CTRL_WR_MASK = 32'h600F_BCFC;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   typedef enum logic [1:0] {UNIT_NONE = 2'd0, UNIT_PROTOCOL = 2'd1,
      UNIT_LINK = 2'd2, UNIT_ROUTE = 2'd3} unit_e;
   typedef enum logic [1:0] {CMP_NONE = 2'd0, CMP_MAX = 2'd1,
      CMP_UPDATE = 2'd2} cmp_e;
   typedef enum logic [2:0] {RST_NONE = 3'd0, RST_P_CMP = 3'd1,
      RST_P_OVF = 3'd2, RST_P_EVENT = 3'd3} rst_e;
   typedef enum logic [1:0] {SRC_EVENT = 2'd0, SRC_PARTNER = 2'd1,
      SRC_CLOCK = 2'd2} src_e;
   typedef enum logic [1:0] {MODE_EVENTS = 2'd0,
      MODE_AFTER_EVENT = 2'd1} mode_e;
   typedef enum logic [2:0] {OUT_GLOBAL = 3'd0, OUT_PARTNER = 3'd1} out_e;
   typedef enum logic [2:0] {EN_OFF = 3'd0, EN_GLOBAL = 3'd1,
      EN_PARTNER = 3'd2} en_e;

   typedef struct packed {
      unit_e unit;
      cmp_e cmp;
      rst_e rst;
      src_e src;
      mode_e mode;
      out_e out;
      en_e en;
   } cfg_s;

   // interrupt status layout: compare bits [3:0], overflow bits [7:4]
   localparam int IRQ_CMP_LSB = 0;
   localparam int IRQ_OVF_LSB = 4;
   localparam int IRQ_W = 8;
endpackage

// ---- perf_counter_block_properties.sv ----
// checker: port-level assertions of the performance counter block
`timescale 1ns/1ps
// ==========================================================
// checker module
module perf_counter_checks
(
   // clock, reset, enable
   input wire logic CLK,
   input wire logic SRST,
   input wire logic CE,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // events, status and interrupt
   input wire logic [3:0] PROTOCOL_ENGINE_UNIT_EVT,
   input wire logic [3:0] LINK_LAYER_UNIT_EVT,
   input wire logic [3:0] ROUTE_THROUGH_UNIT_EVT,
   input wire logic INTERVAL_TIMER_ACTIVE,
   input wire logic [7:0] GLOBAL_STATUS,
   input wire logic IRQ
);
   logic [3:0] wr_hist_reg;
   logic recent_wr;

   // status may only drop shortly after a register write
   always_ff @(posedge CLK)
   begin
      if (SRST)
         wr_hist_reg <= 4'h0;
      else
         wr_hist_reg <= {wr_hist_reg[2:0], PSEL & PENABLE & PWRITE & PREADY};
   end
   assign recent_wr = (|wr_hist_reg) | (PSEL & PENABLE & PWRITE);

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SRST);

   sequence s_setup;
      PSEL && !PENABLE && CE;
   endsequence
   sequence s_access;
      PSEL && PENABLE && CE;
   endsequence

   ready_on_access_a: assert property (
      s_setup ##1 s_access |-> PREADY)
      else $error("no ready in access cycle");
   ready_pulse_a: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   ready_cause_a: assert property (
      PREADY |-> $past(PSEL && !PENABLE))
      else $error("ready without setup");
   err_with_ready_a: assert property (PSLVERR |-> PREADY)
      else $error("error without ready");
   err_read_zero_a: assert property (
      PSLVERR && !PWRITE |-> PRDATA == 32'h0000_0000)
      else $error("refused read not zero");
   rdata_hold_a: assert property (
      !$stable(PRDATA) |-> $past(PSEL && !PENABLE && !PWRITE))
      else $error("read data changed without read");
   reset_quiet_a: assert property (
      $fell(SRST) |-> GLOBAL_STATUS == 8'h00 && !IRQ && !PREADY)
      else $error("outputs not clear after reset");
   status_sticky_a: assert property (
      (|($past(GLOBAL_STATUS) & ~GLOBAL_STATUS)) |-> recent_wr)
      else $error("status dropped without write");
   irq_fall_a: assert property ($fell(IRQ) |-> recent_wr)
      else $error("interrupt dropped without write");
endmodule

bind perf_counter_block perf_counter_checks i_perf_counter_checks (
   .CLK(CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR),
   .PROTOCOL_ENGINE_UNIT_EVT(PROTOCOL_ENGINE_UNIT_EVT),
   .LINK_LAYER_UNIT_EVT(LINK_LAYER_UNIT_EVT),
   .ROUTE_THROUGH_UNIT_EVT(ROUTE_THROUGH_UNIT_EVT),
   .INTERVAL_TIMER_ACTIVE(INTERVAL_TIMER_ACTIVE),
   .GLOBAL_STATUS(GLOBAL_STATUS), .IRQ(IRQ));

// ---- tb.sv ----
// testbench: apb driven self-checking bench of the performance counters
`timescale 1ns/1ps
module tb;
   localparam logic [3:0] sub_ctrl = perf_counter_pkg::OFF_SUB_CTRL;
   localparam logic [3:0] sub_data = perf_counter_pkg::OFF_SUB_DATA;
   localparam logic [3:0] sub_cmp = perf_counter_pkg::OFF_SUB_CMP;
   localparam logic [11:0] glb = perf_counter_pkg::OFF_GLOBAL_CTRL;
   localparam logic [11:0] ist = perf_counter_pkg::OFF_IRQ_STATUS;
   localparam logic [11:0] imk = perf_counter_pkg::OFF_IRQ_MASK;
   localparam logic [31:0] wmask = perf_counter_pkg::CTRL_WR_MASK;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] prot_evt = 4'h0;
   logic [3:0] link_evt = 4'h0;
   logic [3:0] route_evt = 4'h0;
   logic timer = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] gstat;
   logic irq;
   logic [31:0] q;
   logic err;
   int num_errors = 0;
   int total_checks = 0;
   int seed = 69221;

   always #50 clk = ~clk;

   perf_counter_block i_perf_counter_block (
      .CLK(clk), .SRST(srst), .CE(ce), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr),
      .PROTOCOL_ENGINE_UNIT_EVT(prot_evt), .LINK_LAYER_UNIT_EVT(link_evt),
      .ROUTE_THROUGH_UNIT_EVT(route_evt), .INTERVAL_TIMER_ACTIVE(timer),
      .GLOBAL_STATUS(gstat), .IRQ(irq));

   // background traffic on two unit classes
   always @(posedge clk)
   begin
      link_evt <= 4'($random(seed));
      route_evt <= 4'($random(seed));
   end

   // ==========================================================
   // helpers
   task automatic test_done;
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s,
      input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask

   // one apb transfer, entered right after a rising edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         num_errors++;
         test_done();
      end
      @(posedge clk);
   endtask

   function automatic logic [11:0] ra(input int i, input logic [3:0] s);
      ra = perf_counter_pkg::OFF_CNT_BASE
         + 12'(i) * perf_counter_pkg::CNT_STRIDE + 12'(s);
   endfunction

   // control word: unit, compare, source, mode, output, enable
   function automatic logic [31:0] cw(input int u, input int c,
      input int s, input int m, input int o, input int e);
      cw = (32'(u) << perf_counter_pkg::F_UNIT_LSB)
         | (32'(c) << perf_counter_pkg::F_CMP_LSB)
         | (32'(s) << perf_counter_pkg::F_SRC_LSB)
         | (32'(m) << perf_counter_pkg::F_MODE_LSB)
         | (32'(o) << perf_counter_pkg::F_OUT_LSB)
         | (32'(e) << perf_counter_pkg::F_EN_LSB);
   endfunction

   function automatic logic in_rng(input logic [31:0] v, input int lo,
      input int hi);
      in_rng = (v >= 32'(lo)) && (v <= 32'(hi));
   endfunction

   // clear and configure, open the global enable for n cycles, read count
   task automatic run(input int i, input logic [31:0] c,
      input logic [31:0] d, input logic [31:0] k, input logic [31:0] g,
      input int n);
      apb(1'b1, ra(i, sub_ctrl), c | 32'h0000_0001);
      apb(1'b1, ra(i, sub_data), d);
      apb(1'b1, ra(i, sub_cmp), k);
      apb(1'b1, glb, g);
      repeat (n) @(posedge clk);
      apb(1'b1, glb, 32'h0000_0000);
      repeat (4) @(posedge clk);
      apb(1'b0, ra(i, sub_data), 32'h0000_0000);
   endtask

   // ==========================================================
   // main sequence
   initial
   begin
      logic [31:0] d;
      logic [31:0] cnt;
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk("status pins", {23'h0, irq, gstat}, 32'h0000_0000);
      for (int i = 0; i < perf_counter_pkg::NUM_COUNTERS; i++)
      begin
         apb(1'b0, ra(i, sub_ctrl), 32'h0000_0000);
         chk("ctrl reset", q, perf_counter_pkg::CTRL_RESET);
         apb(1'b0, ra(i, sub_data), 32'h0000_0000);
         chk("count reset", q, 32'h0000_0000);
         d = $random(seed);
         apb(1'b1, ra(i, sub_data), d);
         apb(1'b0, ra(i, sub_data), 32'h0000_0000);
         chk("count rw", q, d);
         d = $random(seed);
         apb(1'b1, ra(i, sub_cmp), d);
         apb(1'b0, ra(i, sub_cmp), 32'h0000_0000);
         chk("compare rw", q, d);
         d = $random(seed);
         apb(1'b1, ra(i, sub_ctrl), d);
         apb(1'b0, ra(i, sub_ctrl), 32'h0000_0000);
         chk("ctrl rw", q, d & wmask);
         apb(1'b1, ra(i, sub_ctrl), 32'h0000_0001);
      end
      apb(1'b0, 12'hFFC, 32'h0000_0000);
      chk("unmapped data", q, 32'h0000_0000);
      chk("unmapped err", {31'h0, err}, 32'h0000_0001);
      run(0, cw(0, 0, 2, 0, 0, 0), 0, 0, 1, 30);
      chk("disabled count", q, 32'h0000_0000);
      run(0, cw(0, 0, 2, 0, 0, 1), 0, 0, 1, 30);
      chk("clock count", in_rng(q, 30, 36), 1);
      // clock enable low freezes the running count
      apb(1'b1, ra(0, sub_ctrl), cw(0, 0, 2, 0, 0, 1) | 32'h0000_0001);
      apb(1'b1, glb, 32'h0000_0001);
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      apb(1'b1, glb, 32'h0000_0000);
      apb(1'b0, ra(0, sub_data), 32'h0000_0000);
      chk("frozen count", in_rng(q, 1, 8), 1);
      run(0, cw(0, 0, 2, 0, 0, 1), 0, 0, 3, 30);
      chk("timer idle count", q, 32'h0000_0000);
      timer <= 1'b1;
      run(0, cw(0, 0, 2, 0, 0, 1), 0, 0, 3, 30);
      chk("timer count", in_rng(q, 27, 36), 1);
      timer <= 1'b0;
      prot_evt <= 4'hF;
      run(0, cw(0, 0, 0, 1, 0, 1), 0, 0, 1, 30);
      chk("no unit count", q, 32'h0000_0000);
      run(0, cw(1, 0, 0, 1, 0, 1), 0, 0, 1, 30);
      chk("after event count", in_rng(q, 27, 36), 1);
      prot_evt <= 4'h0;
      run(0, cw(3, 0, 0, 0, 0, 1), 0, 0, 1, 30);
      chk("event count", in_rng(q, 1, 36), 1);
      // maximum compare and interrupt
      run(1, cw(0, 1, 2, 0, 0, 1), 0, 10, 1, 30);
      apb(1'b0, ra(1, sub_ctrl), 32'h0000_0000);
      chk("cmp status", q[9], 1);
      apb(1'b0, ra(1, sub_cmp), 32'h0000_0000);
      chk("cmp kept", q, 32'h0000_000A);
      chk("global cmp", gstat[1], 1);
      apb(1'b0, ist, 32'h0000_0000);
      chk("irq status", q, 32'h0000_0002);
      chk("irq masked", irq, 0);
      apb(1'b1, imk, 32'h0000_0002);
      repeat (3) @(posedge clk);
      chk("irq raised", irq, 1);
      apb(1'b1, ist, 32'h0000_0002);
      repeat (3) @(posedge clk);
      chk("irq cleared", irq, 0);
      apb(1'b1, imk, 32'h0000_0000);
      // compare then update
      run(2, cw(0, 2, 2, 0, 0, 1), 0, 0, 1, 25);
      cnt = q;
      chk("update count", in_rng(cnt, 25, 31), 1);
      apb(1'b0, ra(2, sub_cmp), 32'h0000_0000);
      chk("tracked max", q, cnt);
      // wrap and overflow
      run(3, cw(0, 0, 2, 0, 0, 1), 32'hFFFF_FFF8, 0, 1, 30);
      chk("wrapped count", in_rng(q, 22, 28), 1);
      apb(1'b0, ra(3, sub_ctrl), 32'h0000_0000);
      chk("ovf status", q[8], 1);
      chk("global ovf", gstat[7], 1);
      // clear action
      apb(1'b1, ra(3, sub_ctrl), cw(0, 0, 2, 0, 0, 0) | 32'h0000_0001);
      apb(1'b0, ra(3, sub_data), 32'h0000_0000);
      chk("cleared count", q, 32'h0000_0000);
      apb(1'b0, ra(3, sub_ctrl), 32'h0000_0000);
      chk("cleared ctrl", q, cw(0, 0, 2, 0, 0, 0) & wmask);
      repeat (3) @(posedge clk);
      chk("cleared global", gstat[7], 0);
      // reset source: counter 2 held at zero once partner 3 hits compare
      apb(1'b1, ra(2, sub_ctrl), cw(0, 0, 2, 0, 0, 1) | 32'h0000_8001);
      run(3, cw(0, 1, 2, 0, 0, 1), 0, 5, 1, 30);
      apb(1'b0, ra(2, sub_data), 32'h0000_0000);
      chk("partner reset", q, 32'h0000_0000);
      // partner chain: counter 0 status enables counter 1
      apb(1'b1, ra(1, sub_ctrl), cw(0, 0, 2, 0, 0, 2) | 32'h0000_0001);
      run(0, cw(0, 1, 2, 0, 1, 1), 0, 5, 1, 30);
      apb(1'b0, ra(1, sub_data), 32'h0000_0000);
      chk("partner count", in_rng(q, 1, 99), 1);
      chk("routed away", gstat[0], 0);
      test_done();
   end
endmodule
